/* rtl/dftm_pkg.sv */
// Package with constants and types for the drive fault trip manager
// How it works
// - Heat-sink temperature above limit raises a latched over-heat trip.
// - Excessive short-circuit current from DC detector raises a latched trip.
// - Input terminal set to function 4 raises latched external trip when asserted.
// - Input terminal set to function 5 blocks output while asserted, level type.
// - Memory error, converter offset or either watchdog raises a fatal diagnostic trip.
// - Parameter read or write failure reports as the memory-error cause.
// - Faulty switch temperature sensor raises a latched sensor-open trip.
// - Fan error raises latched fan trip only when fan action is 0, small models.
// - Pre-regulation active and feedback low for persistence time raises latched trip.
// - Brake output function 35 with starting current below threshold latches brake trip.
// - Nonzero lost-command action gives level trip on lost command while running.
// - Missing or poorly connected I/O board raises latched board trip.
// - Hold error lasting beyond 5 s switches to rotating error display pattern.
// - Keypad communication failure during parameter write raises latched trip.
// - With comm option card installed, its comm error raises a latched trip.
// - Thermistor over limit or faulty input raises a latched thermistor trip.
// - Level faults clear by themselves and are never logged in history.
// - Latched faults clear only after condition goes and reset input arrives.
// - Fatal faults persist until power cycle even if condition is gone.
package dftm_pkg;

  localparam int unsigned NUM_DIN = 7;
  localparam int unsigned NUM_FAULT = 16;
  localparam int unsigned CLK_HZ = 200_000_000;

  // Function codes
  localparam logic [7:0] DIN_FUNC_EXT_TRIP = 8'h04;
  localparam logic [7:0] DIN_FUNC_OUT_BLOCK = 8'h05;
  localparam logic [7:0] DOUT_FUNC_BRAKE = 8'h23;
  localparam logic [1:0] FAN_ACTION_TRIP = 2'h0;

  // Hold display timeout
  localparam int unsigned HOLD_TIMEOUT_MS = 5000;
  localparam longint unsigned HOLD_TIMEOUT_CYC =
    longint'(HOLD_TIMEOUT_MS) * longint'(CLK_HZ) / 64'd1000;
  // Rotating display advances one pattern step per this many cycles
  localparam int unsigned ROT_STEP_CYC = 32'h0262_5a00;

  // Register word offsets and reset values
  localparam logic [3:0] REG_DIN_FUNC_LO = 4'h0;
  localparam logic [3:0] REG_DIN_FUNC_HI = 4'h1;
  localparam logic [3:0] REG_CONFIG = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_TRIP = 4'h4;
  localparam logic [3:0] REG_FEEDBACK_TIME = 4'h5;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] FB_TIME_RESET = 32'h0000_03e8;

  // Fault bit positions
  localparam int unsigned F_OVER_HEAT = 0;
  localparam int unsigned F_SHORT_CIRCUIT = 1;
  localparam int unsigned F_EXT_TRIP = 2;
  localparam int unsigned F_OUT_BLOCK = 3;
  localparam int unsigned F_HW_DIAG = 4;
  localparam int unsigned F_SENSOR_OPEN = 5;
  localparam int unsigned F_FAN = 6;
  localparam int unsigned F_FEEDBACK_LOSS = 7;
  localparam int unsigned F_BRAKE = 8;
  localparam int unsigned F_LOST_CMD = 9;
  localparam int unsigned F_BOARD = 10;
  localparam int unsigned F_PARAM_WRITE = 11;
  localparam int unsigned F_OPTION = 12;
  localparam int unsigned F_THERMISTOR = 13;
  localparam int unsigned F_HOLD_ERR = 14;
  localparam int unsigned F_RSVD = 15;

  // Fault classes: level, latch, fatal
  localparam logic [NUM_FAULT-1:0] LEVEL_MASK = 16'h0208;
  localparam logic [NUM_FAULT-1:0] FATAL_MASK = 16'h0010;

  // Diagnostic cause bits
  localparam int unsigned DIAG_MEM = 0;
  localparam int unsigned DIAG_ADC = 1;
  localparam int unsigned DIAG_WDT1 = 2;
  localparam int unsigned DIAG_WDT2 = 3;

  localparam logic [4:0] TRIP_CODE_NONE = 5'h1f;

  typedef enum logic [1:0] {
    DFTM_HOLD_IDLE = 2'b00,
    DFTM_HOLD_WAIT = 2'b01,
    DFTM_HOLD_ROTATE = 2'b10
  } dftm_hold_state_type;

endpackage

/* rtl/dftm_sync.sv */
// Two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module dftm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    if (!rst_n) begin
      meta_d = '0;
      sync_d = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

/* rtl/dftm_top.sv */
// Fault trip manager with Avalon-MM configuration and status registers
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module dftm_top #(
  parameter longint unsigned HOLD_TIMEOUT_CYC = dftm_pkg::HOLD_TIMEOUT_CYC,
  parameter int unsigned ROT_STEP_CYC = dftm_pkg::ROT_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [6:0] din_terminal,
  input wire logic fault_reset_in,
  input wire logic heat_sink_over_temp,
  input wire logic short_circuit_detect,
  input wire logic parameter_memory_error,
  input wire logic param_access_fail,
  input wire logic adc_offset_error,
  input wire logic watchdog1_timeout,
  input wire logic watchdog2_timeout,
  input wire logic switch_sensor_fault,
  input wire logic fan_error,
  input wire logic pre_regulation_active,
  input wire logic feedback_below_min,
  input wire logic start_current_below_brake,
  input wire logic drive_running,
  input wire logic command_lost,
  input wire logic io_board_absent,
  input wire logic keypad_write_comm_fail,
  input wire logic option_card_installed,
  input wire logic option_comm_error,
  input wire logic thermistor_fault,
  input wire logic hold_error,
  output logic pwm_enable,
  output logic trip_active,
  output logic [4:0] trip_code,
  output logic [3:0] diag_cause,
  output logic [15:0] history_event,
  output logic rotate_display,
  output logic [2:0] rotate_phase
);
  localparam int unsigned NF = dftm_pkg::NUM_FAULT;
  localparam int unsigned NUM_ASYNC = 28;

  logic [NUM_ASYNC-1:0] raw_in;
  logic [NUM_ASYNC-1:0] syn;

  assign raw_in = {din_terminal, fault_reset_in, heat_sink_over_temp, short_circuit_detect,
    parameter_memory_error, param_access_fail, adc_offset_error, watchdog1_timeout,
    watchdog2_timeout, switch_sensor_fault, fan_error, pre_regulation_active,
    feedback_below_min, start_current_below_brake, drive_running, command_lost,
    io_board_absent, keypad_write_comm_fail, option_card_installed, option_comm_error,
    thermistor_fault, hold_error};

  // External pins arrive asynchronously; only the synchronised copies are used
  dftm_sync #(.WIDTH(NUM_ASYNC)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(syn)
  );

  logic [6:0] s_din;
  logic s_rst_in, s_heat, s_short, s_mem, s_pacc, s_adc, s_wd1, s_wd2, s_sens, s_fan;
  logic s_prereg, s_fblow, s_brk, s_run, s_lost, s_io, s_kpw, s_opt, s_oerr, s_therm, s_hold;

  assign s_din = syn[NUM_ASYNC-1 -: 7];
  assign {s_rst_in, s_heat, s_short, s_mem, s_pacc, s_adc, s_wd1, s_wd2, s_sens, s_fan,
    s_prereg, s_fblow, s_brk, s_run, s_lost, s_io, s_kpw, s_opt, s_oerr, s_therm,
    s_hold} = syn[NUM_ASYNC-8:0];

  // Configuration registers
  logic [31:0] din_func_lo_q, din_func_lo_d, din_func_hi_q, din_func_hi_d;
  logic [31:0] config_q, config_d, fb_time_q, fb_time_d;

  function automatic logic din_has_func(input logic [63:0] funcs, input logic [6:0] din,
                                        input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < dftm_pkg::NUM_DIN; i++) begin
      if (din[i] && funcs[i*8 +: 8] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  logic [63:0] din_funcs;
  logic [1:0] fan_action;
  logic [7:0] lost_command_action, digital_output_function_one, digital_output_function_two;
  logic small_model;

  assign din_funcs = {din_func_hi_q, din_func_lo_q};
  assign fan_action = config_q[1:0];
  assign small_model = config_q[2];
  assign lost_command_action = config_q[15:8];
  assign digital_output_function_one = config_q[23:16];
  assign digital_output_function_two = config_q[31:24];

  // Fault conditions
  logic [NF-1:0] cond;
  logic fb_low_long, brake_function;
  logic [3:0] diag_now;

  assign brake_function = (digital_output_function_one == dftm_pkg::DOUT_FUNC_BRAKE) ||
    (digital_output_function_two == dftm_pkg::DOUT_FUNC_BRAKE);
  assign diag_now = {s_wd2, s_wd1, s_adc, s_mem | s_pacc};

  always_comb begin
    cond = '0;
    cond[dftm_pkg::F_OVER_HEAT] = s_heat;
    cond[dftm_pkg::F_SHORT_CIRCUIT] = s_short;
    cond[dftm_pkg::F_EXT_TRIP] = din_has_func(din_funcs, s_din,
      dftm_pkg::DIN_FUNC_EXT_TRIP);
    cond[dftm_pkg::F_OUT_BLOCK] = din_has_func(din_funcs, s_din,
      dftm_pkg::DIN_FUNC_OUT_BLOCK);
    cond[dftm_pkg::F_HW_DIAG] = |diag_now;
    cond[dftm_pkg::F_SENSOR_OPEN] = s_sens;
    cond[dftm_pkg::F_FAN] = s_fan && small_model &&
      (fan_action == dftm_pkg::FAN_ACTION_TRIP);
    cond[dftm_pkg::F_FEEDBACK_LOSS] = fb_low_long;
    cond[dftm_pkg::F_BRAKE] = brake_function && s_brk;
    cond[dftm_pkg::F_LOST_CMD] = (lost_command_action != 8'h00) && s_run && s_lost;
    cond[dftm_pkg::F_BOARD] = s_io;
    cond[dftm_pkg::F_PARAM_WRITE] = s_kpw;
    cond[dftm_pkg::F_OPTION] = s_opt && s_oerr;
    cond[dftm_pkg::F_THERMISTOR] = s_therm;
    cond[dftm_pkg::F_HOLD_ERR] = s_hold;
  end

  // Feedback persistence counter
  logic [31:0] fb_cnt_q, fb_cnt_d;
  always_comb begin
    fb_cnt_d = fb_cnt_q;
    if (!(s_prereg && s_fblow)) begin
      fb_cnt_d = '0;
    end else if (fb_cnt_q < fb_time_q) begin
      fb_cnt_d = fb_cnt_q + 32'd1;
    end
    if (!rst_n) begin
      fb_cnt_d = '0;
    end
  end
  assign fb_low_long = s_prereg && s_fblow && (fb_cnt_q >= fb_time_q);

  // Fault state
  logic [NF-1:0] fault_q, fault_d;
  logic [3:0] diag_q, diag_d;
  logic rst_in_q, rst_in_d, reset_edge;
  assign reset_edge = s_rst_in && !rst_in_q;

  always_comb begin
    fault_d = fault_q;
    diag_d = diag_q | diag_now;
    rst_in_d = s_rst_in;
    for (int i = 0; i < NF; i++) begin
      if (dftm_pkg::LEVEL_MASK[i]) begin
        fault_d[i] = cond[i];
      end else if (dftm_pkg::FATAL_MASK[i]) begin
        fault_d[i] = fault_q[i] | cond[i];
      end else if (cond[i]) begin
        fault_d[i] = 1'b1;
      end else if (reset_edge) begin
        fault_d[i] = 1'b0;
      end
    end
    fault_d[dftm_pkg::F_HOLD_ERR] = 1'b0;
    fault_d[dftm_pkg::F_RSVD] = 1'b0;
    if (!rst_n) begin
      fault_d = '0;
      diag_d = '0;
      rst_in_d = 1'b0;
    end
  end

  // History pulses only for newly set non-level faults
  logic [15:0] hist_q, hist_d;
  always_comb begin
    hist_d = fault_d & ~fault_q & ~dftm_pkg::LEVEL_MASK;
    if (!rst_n) begin
      hist_d = '0;
    end
  end

  // Trip code: lowest active bit has priority
  logic [4:0] code_d, code_q;
  logic pwm_d, pwm_q;
  always_comb begin
    code_d = dftm_pkg::TRIP_CODE_NONE;
    for (int i = NF - 1; i >= 0; i--) begin
      if (fault_q[i]) begin
        code_d = 5'(i);
      end
    end
    pwm_d = (fault_q == '0);
    if (!rst_n) begin
      code_d = dftm_pkg::TRIP_CODE_NONE;
      pwm_d = 1'b0;
    end
  end

  // Hold error timer and rotating display
  dftm_pkg::dftm_hold_state_type hold_q, hold_d;
  logic [63:0] hold_cnt_q, hold_cnt_d;
  logic [31:0] rot_cnt_q, rot_cnt_d;
  logic [2:0] phase_q, phase_d;

  always_comb begin
    hold_d = hold_q;
    hold_cnt_d = hold_cnt_q;
    rot_cnt_d = rot_cnt_q;
    phase_d = phase_q;
    unique case (hold_q)
      dftm_pkg::DFTM_HOLD_IDLE: begin
        hold_cnt_d = '0;
        if (cond[dftm_pkg::F_HOLD_ERR]) begin
          hold_d = dftm_pkg::DFTM_HOLD_WAIT;
        end
      end
      dftm_pkg::DFTM_HOLD_WAIT: begin
        if (!cond[dftm_pkg::F_HOLD_ERR]) begin
          hold_d = dftm_pkg::DFTM_HOLD_IDLE;
        end else if (hold_cnt_q >= HOLD_TIMEOUT_CYC - 64'd1) begin
          hold_d = dftm_pkg::DFTM_HOLD_ROTATE;
          rot_cnt_d = '0;
          phase_d = '0;
        end else begin
          hold_cnt_d = hold_cnt_q + 64'd1;
        end
      end
      dftm_pkg::DFTM_HOLD_ROTATE: begin
        if (!cond[dftm_pkg::F_HOLD_ERR]) begin
          hold_d = dftm_pkg::DFTM_HOLD_IDLE;
        end else if (rot_cnt_q >= ROT_STEP_CYC - 32'd1) begin
          rot_cnt_d = '0;
          phase_d = phase_q + 3'd1;
        end else begin
          rot_cnt_d = rot_cnt_q + 32'd1;
        end
      end
      default: begin
        hold_d = dftm_pkg::DFTM_HOLD_IDLE;
      end
    endcase
    if (!rst_n) begin
      hold_d = dftm_pkg::DFTM_HOLD_IDLE;
      hold_cnt_d = '0;
      rot_cnt_d = '0;
      phase_d = '0;
    end
  end

  // Avalon-MM slave; one wait state so read data come from a register
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] resp_q, resp_d;
  logic req, mapped;

  assign req = (avs_read || avs_write) && !ack_q;
  assign mapped = (avs_address <= dftm_pkg::REG_FEEDBACK_TIME);

  always_comb begin
    ack_d = req;
    rdata_d = rdata_q;
    resp_d = mapped ? 2'b00 : 2'b11;
    din_func_lo_d = din_func_lo_q;
    din_func_hi_d = din_func_hi_q;
    config_d = config_q;
    fb_time_d = fb_time_q;
    // Write lands only on the completing edge, when waitrequest is low
    if (ack_q && avs_write) begin
      unique case (avs_address)
        dftm_pkg::REG_DIN_FUNC_LO: din_func_lo_d = avs_writedata;
        dftm_pkg::REG_DIN_FUNC_HI: din_func_hi_d = {8'h00, avs_writedata[23:0]};
        dftm_pkg::REG_CONFIG: config_d = avs_writedata;
        dftm_pkg::REG_FEEDBACK_TIME: fb_time_d = avs_writedata;
        default: ;
      endcase
    end
    if (req && avs_read) begin
      unique case (avs_address)
        dftm_pkg::REG_DIN_FUNC_LO: rdata_d = din_func_lo_q;
        dftm_pkg::REG_DIN_FUNC_HI: rdata_d = din_func_hi_q;
        dftm_pkg::REG_CONFIG: rdata_d = config_q;
        dftm_pkg::REG_STATUS: rdata_d = {16'h0000, fault_q};
        dftm_pkg::REG_TRIP: rdata_d = {17'h0, hold_q == dftm_pkg::DFTM_HOLD_ROTATE, phase_q,
          diag_q, 2'b00, code_q};
        dftm_pkg::REG_FEEDBACK_TIME: rdata_d = fb_time_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (!rst_n) begin
      ack_d = 1'b0;
      rdata_d = '0;
      resp_d = 2'b00;
      din_func_lo_d = dftm_pkg::CONFIG_RESET;
      din_func_hi_d = dftm_pkg::CONFIG_RESET;
      config_d = dftm_pkg::CONFIG_RESET;
      fb_time_d = dftm_pkg::FB_TIME_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    din_func_lo_q <= din_func_lo_d;
    din_func_hi_q <= din_func_hi_d;
    config_q <= config_d;
    fb_time_q <= fb_time_d;
    fb_cnt_q <= fb_cnt_d;
    fault_q <= fault_d;
    diag_q <= diag_d;
    rst_in_q <= rst_in_d;
    hist_q <= hist_d;
    code_q <= code_d;
    pwm_q <= pwm_d;
    hold_q <= hold_d;
    hold_cnt_q <= hold_cnt_d;
    rot_cnt_q <= rot_cnt_d;
    phase_q <= phase_d;
    ack_q <= ack_d;
    rdata_q <= rdata_d;
    resp_q <= resp_d;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata = rdata_q;
  assign avs_response = resp_q;
  assign pwm_enable = pwm_q;
  assign trip_active = !pwm_q;
  assign trip_code = code_q;
  assign diag_cause = diag_q;
  assign history_event = hist_q;
  assign rotate_display = (hold_q == dftm_pkg::DFTM_HOLD_ROTATE);
  assign rotate_phase = phase_q;
endmodule
`default_nettype wire

/* tb/dftm_checker_asserts.sv */
// Port-level checker for the fault trip manager
`timescale 1ns/10ps
`default_nettype none
module dftm_checker #(
  parameter longint unsigned HOLD_TIMEOUT_CYC = dftm_pkg::HOLD_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic heat_sink_over_temp,
  input wire logic short_circuit_detect,
  input wire logic hold_error,
  input wire logic pwm_enable,
  input wire logic trip_active,
  input wire logic [4:0] trip_code,
  input wire logic [3:0] diag_cause,
  input wire logic [15:0] history_event,
  input wire logic rotate_display
);
  logic [31:0] hold_cnt_q;
  logic [31:0] hold_cnt_d;
  // Counts raw input cycles, so the sync latency is slack in the bounds
  always_comb begin
    hold_cnt_d = hold_error ? hold_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_sys) begin
    hold_cnt_q <= rst_n ? hold_cnt_d : 32'h0;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  AST_TRIP_INV: assert property (trip_active == !pwm_enable)
    else $error("trip flag not inverse of enable");
  AST_RUN_NO_CODE: assert property (pwm_enable |-> trip_code == 5'h1f)
    else $error("code shown while running");
  AST_OVER_HEAT: assert property (heat_sink_over_temp [*4] |=>
    !pwm_enable && trip_code == 5'h00)
    else $error("over heat did not trip");
  AST_SHORT: assert property (short_circuit_detect [*4] |=>
    !pwm_enable && trip_code <= 5'h01)
    else $error("short circuit did not trip");
  AST_FATAL: assert property (diag_cause != 4'h0 |=>
    diag_cause != 4'h0 ##1 !pwm_enable)
    else $error("fatal cause lost or output live");
  AST_LEVEL_NO_LOG: assert property ((history_event & dftm_pkg::LEVEL_MASK) == 16'h0)
    else $error("level fault logged");
  AST_HIST_TRIP: assert property (history_event != 16'h0 |=> !pwm_enable)
    else $error("logged fault without trip");
  AST_ROT_LATE: assert property ($rose(rotate_display) |-> hold_cnt_q > HOLD_TIMEOUT_CYC)
    else $error("rotation too early");
  AST_ROT_DUE: assert property (hold_cnt_q == HOLD_TIMEOUT_CYC + 8 |-> rotate_display)
    else $error("rotation missing");
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address > 4'h5
    |-> avs_response == 2'b11 && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  AST_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bad wait sequence");
endmodule
bind dftm_top dftm_checker #(.HOLD_TIMEOUT_CYC(HOLD_TIMEOUT_CYC)) i_dftm_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .heat_sink_over_temp(heat_sink_over_temp),
  .short_circuit_detect(short_circuit_detect), .hold_error(hold_error),
  .pwm_enable(pwm_enable), .trip_active(trip_active), .trip_code(trip_code),
  .diag_cause(diag_cause), .history_event(history_event), .rotate_display(rotate_display)
);
`default_nettype wire

/* tb/dftm_terminal_model.sv */
// Model of the terminal strip and reset button outside the drive
`timescale 1ns/10ps
`default_nettype none
module dftm_terminal_model (
  input wire logic clk_sys,
  input wire logic [6:0] term_level,
  input wire logic reset_press,
  output logic [6:0] din_terminal,
  output logic fault_reset_in
);
  logic [2:0] width_q;
  initial begin
    width_q = 3'h0;
    din_terminal = 7'h00;
    fault_reset_in = 1'b0;
  end
  // Pulse spans four clocks so it survives the two-flop input sync
  always @(posedge clk_sys) begin
    din_terminal <= term_level;
    width_q <= reset_press ? 3'h4 : (width_q != 3'h0 ? width_q - 3'h1 : 3'h0);
    fault_reset_in <= width_q != 3'h0;
  end
endmodule
`default_nettype wire

/* tb/dftm_top_bench.sv */
// Self-checking bench for the fault trip manager
`timescale 1ns/10ps
`default_nettype none
module dftm_top_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [6:0] term_level = 7'h00;
  logic reset_press = 1'b0;
  logic [6:0] din_terminal;
  logic fault_reset_in;
  logic [19:0] flt = 20'h0;
  logic pwm_enable;
  logic trip_active;
  logic [4:0] trip_code;
  logic [3:0] diag_cause;
  logic [15:0] history_event;
  logic rotate_display;
  logic [2:0] rotate_phase;
  logic [31:0] rd;
  logic [1:0] rsp;
  int failures = 0;
  int tests_run = 0;
  logic [19:0] lat_mask [10] = '{20'h00001, 20'h00002, 20'h00080, 20'h00100, 20'h00600,
    20'h00800, 20'h04000, 20'h08000, 20'h30000, 20'h40000};
  logic [4:0] lat_code [10] = '{5'h00, 5'h01, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0b,
    5'h0c, 5'h0d};
  logic [3:0] fat_diag [5] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h8};

  always #2.5 clk_sys = ~clk_sys;

  dftm_top #(.HOLD_TIMEOUT_CYC(50), .ROT_STEP_CYC(10)) i_dftm_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .din_terminal(din_terminal), .fault_reset_in(fault_reset_in),
    .heat_sink_over_temp(flt[0]), .short_circuit_detect(flt[1]),
    .parameter_memory_error(flt[2]), .param_access_fail(flt[3]), .adc_offset_error(flt[4]),
    .watchdog1_timeout(flt[5]), .watchdog2_timeout(flt[6]), .switch_sensor_fault(flt[7]),
    .fan_error(flt[8]), .pre_regulation_active(flt[9]), .feedback_below_min(flt[10]),
    .start_current_below_brake(flt[11]), .drive_running(flt[12]), .command_lost(flt[13]),
    .io_board_absent(flt[14]), .keypad_write_comm_fail(flt[15]),
    .option_card_installed(flt[16]), .option_comm_error(flt[17]),
    .thermistor_fault(flt[18]), .hold_error(flt[19]), .pwm_enable(pwm_enable),
    .trip_active(trip_active), .trip_code(trip_code), .diag_cause(diag_cause),
    .history_event(history_event), .rotate_display(rotate_display), .rotate_phase(rotate_phase)
  );

  dftm_terminal_model i_dftm_terminal_model (
    .clk_sys(clk_sys), .term_level(term_level), .reset_press(reset_press),
    .din_terminal(din_terminal), .fault_reset_in(fault_reset_in)
  );

  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic state_is(input logic [4:0] code);
    chk_word({26'h0, pwm_enable, trip_code}, {26'h0, code == 5'h1f, code});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  // A hung slave is caught by the watchdog, not here
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic press_reset();
    reset_press <= 1'b1;
    @(posedge clk_sys);
    reset_press <= 1'b0;
  endtask

  // About 900 cycles of tests; the limit leaves wide margin
  initial begin
    #50000;
    failures++;
    report_and_stop();
  end

  initial begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(4);
    state_is(5'h1f);
    bus(0, 4'h5, 32'h0);
    chk_word(rd, 32'h3e8);
    bus(1, 4'h0, 32'h0000_0504);
    bus(1, 4'h2, 32'h0023_0104);
    bus(1, 4'h5, 32'h4);
    bus(0, 4'h2, 32'h0);
    chk_word(rd, 32'h0023_0104);
    bus(0, 4'h9, 32'h0);
    chk_word({rsp, rd[29:0]}, {2'b11, 30'h0});
    bus(1, 4'h3, 32'hffff);
    bus(0, 4'h3, 32'h0);
    chk_word(rd, 32'h0);
    $display("Test registers done");
    for (int i = 0; i < 10; i++) begin
      flt <= lat_mask[i];
      cyc(16);
      state_is(lat_code[i]);
      bus(0, 4'h3, 32'h0);
      chk_word(rd, 32'h1 << lat_code[i]);
      press_reset();
      cyc(12);
      state_is(lat_code[i]);
      flt <= 20'h0;
      cyc(8);
      state_is(lat_code[i]);
      press_reset();
      cyc(12);
      state_is(5'h1f);
    end
    $display("Test latched faults done");
    bus(1, 4'h2, 32'h0023_0105);
    flt <= 20'h00100;
    cyc(16);
    state_is(5'h1f);
    flt <= 20'h03000;
    cyc(10);
    state_is(5'h09);
    flt <= 20'h0;
    cyc(10);
    state_is(5'h1f);
    term_level <= 7'h02;
    cyc(12);
    state_is(5'h03);
    term_level <= 7'h00;
    cyc(12);
    state_is(5'h1f);
    term_level <= 7'h01;
    cyc(12);
    state_is(5'h02);
    term_level <= 7'h00;
    cyc(10);
    state_is(5'h02);
    press_reset();
    cyc(12);
    state_is(5'h1f);
    $display("Test level and terminal faults done");
    flt <= 20'h80000;
    cyc(70);
    chk_word({28'h0, rotate_display, rotate_phase}, {28'h0, 1'b1, 3'h1});
    flt <= 20'h0;
    $display("Test hold display done");
    for (int i = 0; i < 5; i++) begin
      rst_n <= 1'b0;
      cyc(4);
      rst_n <= 1'b1;
      cyc(4);
      flt <= 20'h4 << i;
      cyc(10);
      chk_word({23'h0, diag_cause, trip_code}, {23'h0, fat_diag[i], 5'h04});
      flt <= 20'h0;
      press_reset();
      cyc(12);
      state_is(5'h04);
    end
    $display("Test fatal faults done");
    report_and_stop();
  end
endmodule
`default_nettype wire
